//--- include/lpg_if.sv
// Link between program source and generator
`timescale 1ns/1ps
interface lpg_if;
    logic        start;
    logic        port_sel;
    logic        wide;
    logic [2:0]  width_code;
    logic [4:0]  sock_id;
    logic [1:0]  thread_id;
    logic        ent_valid;
    logic        ent_ready;
    logic [127:0] ent_data;
    logic        busy;
    logic        done;
    logic        aborted;

    modport gen (input start, port_sel, wide, width_code, ent_valid, ent_data,
                 output sock_id, thread_id, ent_ready, busy, done, aborted);
    modport src (output start, port_sel, wide, width_code, ent_valid, ent_data,
                 input sock_id, thread_id, ent_ready, busy, done, aborted);
endinterface

//--- include/lpg_pkg.sv
// Loopback generator constants and types
package lpg_pkg;
    // ----------------------------------------
    // Entry layout
    // ----------------------------------------
    localparam int ENT_W     = 128;
    localparam int VALID_BIT = 0;
    localparam int FIRST_BIT = 1;
    localparam int LAST_BIT  = 2;
    localparam int MODE_LO   = 4;
    localparam int MODE_W    = 4;
    localparam int HOLD_LO   = 8;
    localparam int HOLD_W    = 12;
    localparam int SRC_LO    = 20;
    localparam int SRC_W     = 2;
    localparam int CBYTE_LO  = 32;
    localparam int CBYTE_W   = 8;
    localparam int CTRL_LO   = 44;
    localparam int CTRL_W    = 20;
    localparam int PCTRL_W   = 10;
    localparam int DATA_LO   = 64;
    localparam int DATA_W    = 64;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [3:0] MODE_SERIAL  = 4'h0;
    localparam logic [3:0] MODE_PAR_SDR = 4'h2;
    localparam logic [3:0] MODE_PAR_DDR = 4'h3;
    localparam logic [3:0] MODE_ENH_SDR = 4'h4;
    localparam logic [3:0] MODE_ENH_DDR = 4'h5;
    localparam logic [1:0] SRC_REPEAT   = 2'h0;
    localparam logic [1:0] SRC_INC      = 2'h1;
    localparam logic [4:0] SOCK_P0_TEST = 5'h1f;
    localparam logic [1:0] THR_P0_TEST  = 2'h3;
    localparam logic [4:0] SOCK_P1_TEST = 5'h0f;
    localparam logic [1:0] THR_P1_TEST  = 2'h1;
    localparam logic [2:0] WID_8        = 3'h0;
    localparam logic [2:0] WID_16       = 3'h1;
    localparam logic [2:0] WID_24       = 3'h2;
    localparam logic [2:0] WID_32       = 3'h3;
    localparam logic [2:0] WID_64       = 3'h4;

    // ----------------------------------------
    // Register map of the program source
    // ----------------------------------------
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STAT    = 12'h004;
    localparam logic [11:0] REG_IDX     = 12'h008;
    localparam logic [11:0] REG_WORD0   = 12'h010;
    localparam logic [11:0] REG_WORD3   = 12'h01c;
    localparam int         CTL_START    = 0;
    localparam int         CTL_PORT     = 1;
    localparam int         CTL_WIDE     = 2;
    localparam int         CTL_WID_LO   = 4;
    localparam logic [2:0] WIDTH_RST    = WID_64;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ----------------------------------------
    // Types and helpers
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic        first;
        logic        last;
        logic [3:0]  mode;
        logic [11:0] hold;
        logic [1:0]  src;
        logic [7:0]  cbyte;
        logic [19:0] ctrl;
        logic [63:0] data;
    } fields_type;

    function automatic logic [63:0] width_mask(input logic [2:0] code);
        case (code)
            WID_8:   width_mask = 64'h0000_0000_0000_00ff;
            WID_16:  width_mask = 64'h0000_0000_0000_ffff;
            WID_24:  width_mask = 64'h0000_0000_00ff_ffff;
            WID_32:  width_mask = 64'h0000_0000_ffff_ffff;
            default: width_mask = 64'hffff_ffff_ffff_ffff;
        endcase
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge_strb[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
        end
    endfunction
endpackage

//--- logic/entry_fields.sv
// Splits one 128-bit program entry into its fields
`timescale 1ns/1ps
module entry_fields
    import lpg_pkg::*;
(
    // Raw entry
    input  wire logic [127:0] ent,
    // Decoded fields
    output fields_type        fld
);
    // [RULE20] reserved bits ignored
    assign fld.valid = ent[VALID_BIT];
    assign fld.first = ent[FIRST_BIT];
    assign fld.last  = ent[LAST_BIT];
    assign fld.mode  = ent[MODE_LO +: MODE_W];
    assign fld.hold  = ent[HOLD_LO +: HOLD_W];
    assign fld.src   = ent[SRC_LO +: SRC_W];
    assign fld.cbyte = ent[CBYTE_LO +: CBYTE_W];
    assign fld.ctrl  = ent[CTRL_LO +: CTRL_W];
    assign fld.data  = ent[DATA_LO +: DATA_W];
endmodule // entry_fields

//--- logic/pattern_gen.sv
// Loopback pattern generator
//
// Functional notes
// [RULE1] Entries are 128 bits, fixed layout
// [RULE2] Only entries with valid bit set run
// [RULE3] First entry: start bit, mode only
// [RULE4] Stop after entry carrying end bit
// [RULE5] Mode taken from bits 7:4 at start
// [RULE6] Hold count sets cycles per entry
// [RULE7] Source 00 repeats entry data unchanged
// [RULE8] Source 01 increments replicated low byte; code does so only when hold is above one
// [RULE9] Control byte only serial or enhanced
// [RULE10] Control bits split per port, wide all
// [RULE11] Wide link duplicates 64-bit data
// [RULE12] Data cut to configured bus width
// [RULE13] Port 0 test: thread 3, socket 31
// [RULE14] Port 1 test: thread 1, socket 15
// [RULE15] Wide port under test not supported
// [RULE16] Threads 1 and 3 reserved
// [RULE17] Cross-connect at link-layer signals only
// [RULE18] Program loaded before the test starts
// [RULE19] Program fetched through consumer socket
// [RULE20] Reserved bits zero, ignored
// [RULE21] Invalid entry before end aborts run
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pattern_gen
    import lpg_pkg::*;
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Program source side
    lpg_if.gen                bus,
    // Port 0 link-layer stimulus
    output logic [19:0]       lnk0_ctrl,
    output logic [127:0]      lnk0_data,
    output logic [7:0]        lnk0_cbyte,
    output logic              lnk0_strobe,
    // Port 1 link-layer stimulus
    output logic [9:0]        lnk1_ctrl,
    output logic [63:0]       lnk1_data,
    output logic [7:0]        lnk1_cbyte,
    output logic              lnk1_strobe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_HOLD  = 2'b10
    } gen_state_type;

    typedef struct packed {
        gen_state_type st;
        logic          first;
        logic          lst;
        logic [3:0]    mode;
        logic [11:0]   cnt;
        logic          inc;
        logic [7:0]    cur;
        logic [7:0]    cbyte;
        logic [19:0]   ctrl;
        logic [63:0]   data;
        logic          port;
        logic          wide;
        logic [2:0]    wcode;
        logic          busy;
        logic          done;
        logic          abort;
        logic [19:0]   o0_ctrl;
        logic [127:0]  o0_data;
        logic [7:0]    o0_cbyte;
        logic          o0_stb;
        logic [9:0]    o1_ctrl;
        logic [63:0]   o1_data;
        logic [7:0]    o1_cbyte;
        logic          o1_stb;
    } gen_reg_type;

    localparam gen_reg_type GEN_RST = '{st: ST_IDLE, wcode: WIDTH_RST, default: '0};

    gen_reg_type r_r;
    gen_reg_type r_nxt;
    fields_type  fld;
    logic [63:0] word;
    logic [7:0]  cb;

    // Clean end of a run
    function automatic gen_reg_type end_run(input gen_reg_type s);
        end_run      = s;
        end_run.st   = ST_IDLE;
        end_run.busy = 1'b0;
        end_run.done = 1'b1;
    endfunction

    // ----------------------------------------
    // Entry decode
    // ----------------------------------------
    // [RULE1] fixed field split
    entry_fields u_fields (
        .ent (bus.ent_data),
        .fld (fld)
    );

    // ----------------------------------------
    // Fetch side
    // ----------------------------------------
    // [RULE13] [RULE14] socket per port
    assign bus.sock_id   = r_r.port ? SOCK_P1_TEST : SOCK_P0_TEST;
    assign bus.thread_id = r_r.port ? THR_P1_TEST : THR_P0_TEST;
    // [RULE19] pull entries from socket
    assign bus.ent_ready = (r_r.st == ST_FETCH);
    assign bus.busy      = r_r.busy;
    assign bus.done      = r_r.done;
    assign bus.aborted   = r_r.abort;

    // ----------------------------------------
    // Stimulus shaping
    // ----------------------------------------
    always_comb begin
        // [RULE8] replicated counting byte
        word = r_r.inc ? {8{r_r.cur}} : r_r.data;
        // [RULE12] cut to bus width
        word = word & width_mask(r_r.wcode);
        // [RULE9] control byte gating
        cb = (r_r.mode == MODE_SERIAL || r_r.mode == MODE_ENH_SDR || r_r.mode == MODE_ENH_DDR)
           ? r_r.cbyte : 8'h00;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        r_nxt        = r_r;
        r_nxt.o0_stb = 1'b0;
        r_nxt.o1_stb = 1'b0;
        case (r_r.st)
            ST_IDLE: begin
                // [RULE18] waits for software start
                if (bus.start) begin
                    r_nxt.st    = ST_FETCH;
                    r_nxt.first = 1'b1;
                    r_nxt.port  = bus.port_sel;
                    r_nxt.wide  = bus.wide;
                    r_nxt.wcode = bus.width_code;
                    r_nxt.busy  = 1'b1;
                    r_nxt.done  = 1'b0;
                    r_nxt.abort = 1'b0;
                end
            end
            ST_FETCH: begin
                if (bus.ent_valid) begin
                    // [RULE2] [RULE21] invalid entry aborts
                    if (!fld.valid || (r_r.first && !fld.first)) begin
                        r_nxt.st    = ST_IDLE;
                        r_nxt.busy  = 1'b0;
                        r_nxt.abort = 1'b1;
                    end else if (r_r.first) begin
                        // [RULE3] [RULE5] start entry: mode only
                        r_nxt.first = 1'b0;
                        r_nxt.mode  = fld.mode;
                        // [RULE4] end on start entry
                        if (fld.last) begin
                            r_nxt = end_run(r_nxt);
                        end
                    end else begin
                        r_nxt.lst   = fld.last;
                        r_nxt.cnt   = fld.hold;
                        r_nxt.cbyte = fld.cbyte;
                        r_nxt.ctrl  = fld.ctrl;
                        r_nxt.data  = fld.data;
                        r_nxt.cur   = fld.data[7:0];
                        // [RULE7] [RULE8] source only counts above one
                        r_nxt.inc   = (fld.src == SRC_INC) && (fld.hold > 12'h001);
                        if (fld.hold != 12'h000) begin
                            r_nxt.st = ST_HOLD;
                        end else if (fld.last) begin
                            // [RULE4] zero-hold end entry
                            r_nxt = end_run(r_nxt);
                        end
                    end
                end
            end
            ST_HOLD: begin
                // [RULE17] link-layer signals
                // [RULE10] control split per port
                if (r_r.wide) begin
                    // [RULE15] wide link only ever feeds port 0
                    r_nxt.o0_ctrl  = r_r.ctrl;
                    // [RULE11] duplicated data word
                    r_nxt.o0_data  = {word, word};
                    r_nxt.o0_cbyte = cb;
                    r_nxt.o0_stb   = 1'b1;
                end else begin
                    r_nxt.o0_ctrl = {10'h000, r_r.ctrl[PCTRL_W-1:0]};
                    r_nxt.o1_ctrl = r_r.ctrl[CTRL_W-1:PCTRL_W];
                    if (!r_r.port) begin
                        r_nxt.o0_data  = {64'h0, word};
                        r_nxt.o0_cbyte = cb;
                        r_nxt.o0_stb   = 1'b1;
                    end else begin
                        r_nxt.o1_data  = word;
                        r_nxt.o1_cbyte = cb;
                        r_nxt.o1_stb   = 1'b1;
                    end
                end
                // [RULE8] next byte one cycle later
                r_nxt.cur = r_r.cur + 8'h01;
                // [RULE6] count down hold cycles
                r_nxt.cnt = r_r.cnt - 12'h001;
                if (r_r.cnt == 12'h001) begin
                    if (r_r.lst) begin
                        // [RULE4] stop after end entry
                        r_nxt = end_run(r_nxt);
                    end else begin
                        r_nxt.st = ST_FETCH;
                    end
                end
            end
            default: begin
                r_nxt = GEN_RST;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r <= GEN_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Data and control byte keep the last value between strobes; every non-wide beat sets both control words
    assign lnk0_ctrl   = r_r.o0_ctrl;
    assign lnk0_data   = r_r.o0_data;
    assign lnk0_cbyte  = r_r.o0_cbyte;
    assign lnk0_strobe = r_r.o0_stb;
    assign lnk1_ctrl   = r_r.o1_ctrl;
    assign lnk1_data   = r_r.o1_data;
    assign lnk1_cbyte  = r_r.o1_cbyte;
    assign lnk1_strobe = r_r.o1_stb;
endmodule // pattern_gen

//--- logic/program_source.sv
// Program store, socket and register port
`timescale 1ns/1ps
module program_source
    import lpg_pkg::*;
#(
    parameter int DEPTH = 256
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Generator side
    lpg_if.src               bus,
    // AXI4-Lite write
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    localparam int IW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH > 4096) begin : g_bad_depth
        $error("program_source: DEPTH must be 2..4096");
    end

    typedef struct packed {
        logic          aw_got;
        logic [11:0]   awaddr;
        logic          w_got;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
        logic          start;
        logic          port;
        logic          wide;
        logic [2:0]    wcode;
        logic [31:0]   idx;
        logic [IW-1:0] ptr;
    } src_reg_type;

    localparam src_reg_type SRC_RST = '{wcode: WIDTH_RST, default: '0};

    src_reg_type  r_r;
    src_reg_type  r_nxt;
    logic [127:0] mem [DEPTH];
    logic         mem_we;
    logic [1:0]   mem_lane;
    logic [31:0]  ctrl_word;

    // Offered only to the matching socket
    assign bus.ent_valid  = (bus.sock_id == (r_r.port ? SOCK_P1_TEST : SOCK_P0_TEST));
    assign bus.ent_data   = mem[r_r.ptr];
    assign bus.start      = r_r.start;
    assign bus.port_sel   = r_r.port;
    assign bus.wide       = r_r.wide;
    assign bus.width_code = r_r.wcode;

    assign ctrl_word = {25'h0, r_r.wcode, 1'b0, r_r.wide, r_r.port, 1'b0};
    assign mem_lane  = r_r.awaddr[3:2];

    // Aligned entry word address
    function automatic logic word_hit(input logic [11:0] a);
        return a >= REG_WORD0 && a <= REG_WORD3 && a[1:0] == 2'h0;
    endfunction

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    always_comb begin
        r_nxt       = r_r;
        r_nxt.start = 1'b0;
        mem_we      = 1'b0;
        if (bus.ent_valid && bus.ent_ready) begin
            r_nxt.ptr = r_r.ptr + 1'b1;
        end
        if (awvalid && !r_r.aw_got) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = awaddr;
        end
        if (wvalid && !r_r.w_got) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = wdata;
            r_nxt.wstrb = wstrb;
        end
        if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got  = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = RESP_OKAY;
            if (r_r.awaddr == REG_CTRL) begin
                if (r_r.wstrb[0]) begin
                    r_nxt.start = r_r.wdata[CTL_START] && !bus.busy;
                    r_nxt.port  = r_r.wdata[CTL_PORT];
                    r_nxt.wide  = r_r.wdata[CTL_WIDE];
                    r_nxt.wcode = r_r.wdata[CTL_WID_LO +: 3];
                    if (r_r.wdata[CTL_START] && !bus.busy) begin
                        r_nxt.ptr = '0;
                    end
                end
            end else if (r_r.awaddr == REG_IDX) begin
                r_nxt.idx = merge_strb(r_r.idx, r_r.wdata, r_r.wstrb);
            end else if (word_hit(r_r.awaddr) && r_r.idx < DEPTH) begin
                mem_we = 1'b1;
            end else begin
                r_nxt.bresp = RESP_SLVERR;
            end
        end
        if (r_r.bvalid && bready) begin
            r_nxt.bvalid = 1'b0;
        end
        if (arvalid && !r_r.rvalid) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp  = RESP_OKAY;
            r_nxt.rdata  = 32'h0;
            if (araddr == REG_CTRL) begin
                r_nxt.rdata = ctrl_word;
            end else if (araddr == REG_STAT) begin
                r_nxt.rdata = {29'h0, bus.aborted, bus.done, bus.busy};
            end else if (araddr == REG_IDX) begin
                r_nxt.rdata = r_r.idx;
            end else if (word_hit(araddr) && r_r.idx < DEPTH) begin
                r_nxt.rdata = mem[r_r.idx[IW-1:0]][32*araddr[3:2] +: 32];
            end else begin
                r_nxt.rresp = RESP_SLVERR;
            end
        end else if (r_r.rvalid && rready) begin
            r_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r <= SRC_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Store not reset; contents kept across runs
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[r_r.idx[IW-1:0]][32*mem_lane +: 32] <=
                merge_strb(mem[r_r.idx[IW-1:0]][32*mem_lane +: 32], r_r.wdata, r_r.wstrb);
        end
    end

    assign awready = !r_r.aw_got;
    assign wready  = !r_r.w_got;
    assign bvalid  = r_r.bvalid;
    assign bresp   = r_r.bresp;
    assign arready = !r_r.rvalid;
    assign rvalid  = r_r.rvalid;
    assign rdata   = r_r.rdata;
    assign rresp   = r_r.rresp;
endmodule // program_source

//--- verif/lpg_sva.sv
// Checker on the link between program source and pattern generator
`timescale 1ns/1ps
module lpg_sva
    import lpg_pkg::*;
(
    // Clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // Link signals
    input wire logic         start,
    input wire logic         port_sel,
    input wire logic [4:0]   sock_id,
    input wire logic [1:0]   thread_id,
    input wire logic         ent_valid,
    input wire logic         ent_ready,
    input wire logic [127:0] ent_data,
    input wire logic         busy,
    input wire logic         done,
    input wire logic         aborted
);
    wire logic take = ent_valid && ent_ready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------
    // Properties
    // ------------------------------------
    AST_START_BUSY: assert property (start && !busy |=> busy)
        else $error("start ignored");
    AST_SOCK_PORT0: assert property (busy && !port_sel
        |-> sock_id == 5'h1f && thread_id == 2'h3) else $error("bad port 0 socket");
    AST_SOCK_PORT1: assert property (busy && port_sel
        |-> sock_id == 5'h0f && thread_id == 2'h1) else $error("bad port 1 socket");
    AST_FETCH_BUSY: assert property (ent_ready |-> busy && !done && !aborted)
        else $error("stray fetch");
    AST_INVALID_ABORT: assert property (take && !ent_data[0] |=> aborted && !busy)
        else $error("no abort");
    // Short holds only
    AST_END_DONE: assert property (take && ent_data[2:0] == 3'b101
        && ent_data[19:8] < 12'h008 |-> ##[1:12] done) else $error("no done");
    AST_DONE_IDLE: assert property (done |-> !busy && !ent_ready)
        else $error("busy after end");
    AST_ABORT_CLEAN: assert property ($rose(aborted) |-> !busy && !done)
        else $error("abort left run going");
    AST_ENTRY_HELD: assert property (busy && ent_valid && !ent_ready
        |=> $stable(ent_data)) else $error("entry changed");
    cover property ($rose(done));
    cover property ($rose(aborted));
    cover property (take && port_sel);
endmodule // lpg_sva

//--- verif/test_link_loopback_pattern_gen.sv
// Bench joining the program source and the generator over the link
`timescale 1ns/1ps
module test_link_loopback_pattern_gen
    import lpg_pkg::*;
;
    logic         aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b1;
    logic         arv = 1'b0, rready = 1'b1, awr, wr, bvalid, arr, rvalid, s0, s1;
    logic [11:0]  awa = 12'h000, ara = 12'h000;
    logic [31:0]  wd = 32'h0, rdata, rd;
    logic [1:0]   bresp, rresp, rr;
    logic [19:0]  c0;
    logic [9:0]   c1;
    logic [127:0] d0;
    logic [63:0]  d1;
    logic [7:0]   b0, b1;
    logic [155:0] q0[$];
    logic [81:0]  q1[$];
    int           failures = 0, n_checks = 0, cycles = 0;
    always #5 aclk = ~aclk;
    lpg_if lk ();
    program_source #(.DEPTH(16)) program_source_inst (.aclk(aclk), .aresetn(aresetn),
        .bus(lk.src), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(4'hf),
        .wvalid(wv), .wready(wr), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    pattern_gen pattern_gen_inst (.aclk(aclk), .aresetn(aresetn), .bus(lk.gen),
        .lnk0_ctrl(c0), .lnk0_data(d0), .lnk0_cbyte(b0), .lnk0_strobe(s0),
        .lnk1_ctrl(c1), .lnk1_data(d1), .lnk1_cbyte(b1), .lnk1_strobe(s1));
    lpg_sva sva (.aclk(aclk), .aresetn(aresetn), .start(lk.start), .port_sel(lk.port_sel),
        .sock_id(lk.sock_id), .thread_id(lk.thread_id), .ent_valid(lk.ent_valid),
        .ent_ready(lk.ent_ready),
        .ent_data(lk.ent_data), .busy(lk.busy), .done(lk.done), .aborted(lk.aborted));
    // ------------------------------------
    // Beat capture, hang guard, helpers
    // ------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (s0 === 1'b1) q0.push_back({b0, c0, d0});
        if (s1 === 1'b1) q1.push_back({b1, c1, d1});
        if (cycles == 30000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [155:0] exp, input logic [155:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [155:0] pop(input bit p);
        if (p) return q1.size() > 0 ? 156'(q1.pop_front()) : 'x;
        return q0.size() > 0 ? q0.pop_front() : 'x;
    endfunction
    function automatic logic [127:0] mk(input logic [2:0] f, input logic [3:0] md,
        input logic [11:0] h, input logic [1:0] sr, input logic [7:0] cb,
        input logic [19:0] ct, input logic [63:0] dt);
        return {dt, ct, 4'h0, cb, 10'h0, sr, h, md, 1'b0, f};
    endfunction
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic ta = 1'b0, tw = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awr === 1'b1) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (!tw && wr === 1'b1) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("write response", RESP_OKAY, bresp);
    endtask
    task automatic axi_rd(input logic [11:0] a);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
    endtask
    task automatic load(input logic [31:0] idx, input logic [127:0] e);
        axi_wr(REG_IDX, idx);
        for (int i = 0; i < 4; i++) axi_wr(REG_WORD0 + 12'(4 * i), e[32*i +: 32]);
    endtask
    task automatic run(input logic [2:0] w, input logic wide, input logic port);
        q0.delete();
        q1.delete();
        axi_wr(REG_CTRL, {25'h0, w, 1'b0, wide, port, 1'b1});
        repeat (3) @(posedge aclk);
        while (!(lk.done || lk.aborted)) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task automatic scen_inc_repeat();
        load(0, mk(3'b011, MODE_SERIAL, 12'd5, SRC_INC, 8'h77, 20'hfffff, 64'hffff));
        load(1, mk(3'b001, MODE_ENH_DDR, 12'd3, SRC_INC, 8'h5a, 20'habcde,
            64'h1122_3344_5566_77fe) | 128'hf00_ffc0_0008);
        load(2, mk(3'b101, MODE_PAR_SDR, 12'd2, SRC_REPEAT, 8'h3c, 20'h12345,
            64'h0123_4567_89ab_cdef));
        run(WID_32, 1'b0, 1'b0);
        chk("port0 beats", 5, q0.size());
        for (int k = 0; k < 3; k++)
            chk("inc beat", {8'h5a, 20'h000de, 96'h0, {4{8'hfe + 8'(k)}}}, pop(0));
        repeat (2) chk("repeat beat", {8'h3c, 20'h00345, 96'h0, 32'h89ab_cdef}, pop(0));
        chk("port1 beats", 0, q1.size());
        axi_rd(REG_STAT);
        chk("status", 3'b010, rd);
    endtask
    task automatic scen_modes();
        logic [3:0] md [5];
        logic [7:0] cb;
        md = '{MODE_SERIAL, MODE_PAR_SDR, MODE_PAR_DDR, MODE_ENH_SDR, MODE_ENH_DDR};
        load(1, mk(3'b101, 4'h0, 12'd1, SRC_REPEAT, 8'h5a, 20'hcafe5, 64'h0f1e_2d3c_4b5a_6978));
        foreach (md[i]) begin
            load(0, mk(3'b011, md[i], 12'd0, 2'h0, 8'h0, 20'h0, 64'h0));
            run(WID_64, 1'b0, 1'b1);
            cb = (md[i] == MODE_SERIAL || md[i] >= MODE_ENH_SDR) ? 8'h5a : 8'h00;
            chk("port1 beat", {74'h0, cb, 10'h32b, 64'h0f1e_2d3c_4b5a_6978}, pop(1));
            chk("port0 beats", 0, q0.size());
        end
    endtask
    task automatic scen_wide_abort();
        load(0, mk(3'b011, MODE_ENH_SDR, 12'd0, 2'h0, 8'h0, 20'h0, 64'h0));
        load(1, mk(3'b101, 4'h0, 12'd2, SRC_REPEAT, 8'h81, 20'hcafe5, 64'h0f1e_2d3c_4b5a_6978));
        run(WID_64, 1'b1, 1'b0);
        repeat (2) chk("wide beat", {8'h81, 20'hcafe5, {2{64'h0f1e_2d3c_4b5a_6978}}}, pop(0));
        chk("port1 beats", 0, q1.size());
        load(1, mk(3'b001, 4'h0, 12'd1, SRC_REPEAT, 8'h00, 20'h00001, 64'h00a5));
        load(2, 128'h0);
        run(WID_8, 1'b0, 1'b0);
        chk("beats before abort", 1, q0.size());
        axi_rd(REG_STAT);
        chk("status", 3'b100, rd);
        axi_rd(12'h0f0);
        chk("unmapped read", {RESP_SLVERR, 32'h0}, {rr, rd});
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        scen_inc_repeat();
        scen_modes();
        scen_wide_abort();
        give_verdict();
    end
endmodule // test_link_loopback_pattern_gen
